// [rtl/vrsp_pkg.sv]
package vrsp_pkg;

  // widths of the serial side and of the apb address
  localparam int unsigned VRSP_COL_W  = 9;
  localparam int unsigned VRSP_DATA_W = 16;
  localparam int unsigned VRSP_STOP_W = 8;
  localparam int unsigned VRSP_ADDR_W = 12;

  // apb register byte offsets
  localparam logic [VRSP_ADDR_W-1:0] VRSP_STATUS_OFS = 12'h000;
  localparam logic [VRSP_ADDR_W-1:0] VRSP_INDEX_OFS  = 12'h004;
  localparam logic [VRSP_ADDR_W-1:0] VRSP_DATA_OFS   = 12'h008;

  // status register field positions
  localparam int unsigned VRSP_ST_MODE_BIT  = 0;
  localparam int unsigned VRSP_ST_EMPTY_BIT = 1;
  localparam int unsigned VRSP_ST_HALF_BIT  = 2;
  localparam int unsigned VRSP_ST_PEND_BIT  = 3;
  localparam int unsigned VRSP_ST_PTR_LSB   = 8;
  localparam int unsigned VRSP_ST_STOP_LSB  = 20;

  // reset values and column constants
  localparam logic [VRSP_STOP_W-1:0] VRSP_STOP_RST  = 8'hFF;
  localparam logic [VRSP_COL_W-1:0]  VRSP_COL_ZERO  = 9'h000;
  localparam logic [VRSP_COL_W-1:0]  VRSP_COL_ONE   = 9'h001;
  localparam logic [VRSP_COL_W-1:0]  VRSP_COL_LAST  = 9'h1FF;
  localparam logic [VRSP_COL_W-1:0]  VRSP_HALF_MASK = 9'h0FF;
  localparam logic [3:0]             VRSP_STOP_LOW  = 4'hF;
  localparam logic [31:0]            VRSP_WORD_ZERO = 32'h0000_0000;
  localparam logic [VRSP_DATA_W-1:0] VRSP_SER_ZERO  = 16'h0000;

  typedef enum logic {
    VRSP_MODE_WRITE,
    VRSP_MODE_READ
  } vrsp_mode_t;

  // pin levels as sampled, one group per synchroniser stage
  typedef struct packed {
    logic                   ras_n;
    logic                   cas_n;
    logic                   toe_n;
    logic                   upper_wr_n;
    logic                   lower_wr_n;
    logic                   split_sel;
    logic                   shift_clk;
    logic                   ser_en_n;
    logic [VRSP_COL_W-1:0]  addr;
    logic [VRSP_DATA_W-1:0] ser_data;
  } vrsp_pins_t;

  typedef struct packed {
    vrsp_pins_t             s1;
    vrsp_pins_t             s2;
    logic                   ras_d;
    logic                   cas_d;
    logic                   shift_clk_d;
    logic                   xfer_set;
    logic                   xfer_wr;
    logic                   xfer_split;
    vrsp_mode_t             mode;
    logic [VRSP_COL_W-1:0]  tap;
    logic                   tap_empty;
    logic [VRSP_COL_W-1:0]  ptr;
    logic [VRSP_STOP_W-1:0] stop;
    logic [VRSP_DATA_W-1:0] ser_out;
    logic                   ser_oe;
    logic                   half;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic [VRSP_COL_W-1:0]  index;
  } vrsp_state_t;

endpackage

// [rtl/vrsp_serial_port.sv]
`timescale 1ns/100ps
// What this block does
// R1: power-up in write mode, pins undriven
// R2: only single read transfer selects read
// R3: read mode drives pointed word each rise
// R4: enable high floats outputs, pointer still moves
// R5: only single write transfer selects write
// R6: controller masks all bits entering write mode
// R7: write mode captures pins at pointer
// R8: enable high keeps old word, pointer moves
// R9: half flag shows next access column msb
// R10: column strobe fall loads start point
// R11: execution uses start point, then empties it
// R12: split transfer picks inactive half msb
// R13: empty start point: wrap, no jumps
// R14: refresh with byte writes low loads jumps
// R15: leading zeros choose jump segment size
// R16: jump register resets to all ones
// R17: jump source with split start jumps
// R18: single transfer initialises whole serial port
// R19: controller repeats split transfer per jump
// R20: split moves only the inactive half
// R21: pointer laps through all columns
// R22: nine-bit pointer increments every clock rise
module vrsp_serial_port
(
  // apb clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [vrsp_pkg::VRSP_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic [31:0]                            prdata,
  output logic                                   pslverr,
  // strobes and address pins
  input  wire logic                              ras_n,
  input  wire logic                              cas_n,
  input  wire logic                              transfer_output_enable_n,
  input  wire logic                              upper_byte_write_n,
  input  wire logic                              lower_byte_write_n,
  input  wire logic                              split_sel,
  input  wire logic [vrsp_pkg::VRSP_COL_W-1:0]   addr,
  // serial port pins
  input  wire logic                              serial_shift_clock,
  input  wire logic                              serial_enable_n,
  input  wire logic [vrsp_pkg::VRSP_DATA_W-1:0]  serial_data_pins_in,
  output logic [vrsp_pkg::VRSP_DATA_W-1:0]       serial_data_pins_out,
  output logic                                   serial_data_pins_oe,
  output logic                                   half_select_flag
);

  localparam int unsigned DEPTH = 1 << vrsp_pkg::VRSP_COL_W;

  vrsp_pkg::vrsp_state_t                st_r;
  vrsp_pkg::vrsp_state_t                st_nxt;
  vrsp_pkg::vrsp_pins_t                 pins;
  logic [vrsp_pkg::VRSP_DATA_W-1:0]     serial_reg [DEPTH];
  logic [vrsp_pkg::VRSP_DATA_W-1:0]     ser_word;
  logic [vrsp_pkg::VRSP_DATA_W-1:0]     apb_word;
  logic                                 ras_fall;
  logic                                 ras_rise;
  logic                                 cas_fall;
  logic                                 shift_rise;
  logic                                 jump_hit;
  logic                                 exec_xfer;
  logic                                 stop_load;
  logic                                 ser_we;
  logic                                 apb_access;
  logic                                 apb_we;

  // a jump source is the last column of a segment; a pattern with low bits
  // not all ones selects no jump source at all
  function automatic logic is_jump_src(input logic [vrsp_pkg::VRSP_COL_W-1:0]  col,
                                       input logic [vrsp_pkg::VRSP_STOP_W-1:0] stop);
    logic [vrsp_pkg::VRSP_COL_W-1:0] mask;
    mask = vrsp_pkg::VRSP_HALF_MASK;
    for (int i = vrsp_pkg::VRSP_STOP_W - 1; i >= 4; i--)
    begin
      if (stop[i] == 1'b0 && mask[i] == 1'b1)
      begin
        mask = mask >> 1;
      end
      else
      begin
        break;
      end
    end
    is_jump_src = (stop[3:0] == vrsp_pkg::VRSP_STOP_LOW) && ((col & mask) == mask); // R15
  endfunction

  function automatic logic is_mapped(input logic [vrsp_pkg::VRSP_ADDR_W-1:0] a);
    is_mapped = (a == vrsp_pkg::VRSP_STATUS_OFS) || (a == vrsp_pkg::VRSP_INDEX_OFS) ||
                (a == vrsp_pkg::VRSP_DATA_OFS);
  endfunction

  assign pins = '{ras_n: ras_n, cas_n: cas_n, toe_n: transfer_output_enable_n,
                  upper_wr_n: upper_byte_write_n, lower_wr_n: lower_byte_write_n,
                  split_sel: split_sel, shift_clk: serial_shift_clock,
                  ser_en_n: serial_enable_n, addr: addr, ser_data: serial_data_pins_in};

  // edges are found on the second stage only
  assign ras_fall   = st_r.ras_d & ~st_r.s2.ras_n;
  assign ras_rise   = ~st_r.ras_d & st_r.s2.ras_n;
  assign cas_fall   = st_r.cas_d & ~st_r.s2.cas_n;
  assign shift_rise = ~st_r.shift_clk_d & st_r.s2.shift_clk;
  assign jump_hit   = ~st_r.tap_empty & is_jump_src(st_r.ptr, st_r.stop); // R13 R17
  assign exec_xfer  = ras_rise & st_r.xfer_set;
  assign stop_load  = ras_fall & ~st_r.s2.cas_n & ~st_r.s2.upper_wr_n & ~st_r.s2.lower_wr_n; // R14
  assign ser_we     = shift_rise & (st_r.mode == vrsp_pkg::VRSP_MODE_WRITE) & ~st_r.s2.ser_en_n;
  assign apb_access = psel & penable;
  assign apb_we     = apb_access & st_r.pready & pwrite &
                      (paddr == vrsp_pkg::VRSP_DATA_OFS);
  assign ser_word   = serial_reg[st_r.ptr];
  assign apb_word   = serial_reg[st_r.index];

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.s1    = pins;
    st_nxt.s2    = st_r.s1;
    st_nxt.ras_d = st_r.s2.ras_n;
    st_nxt.cas_d = st_r.s2.cas_n;
    st_nxt.shift_clk_d = st_r.s2.shift_clk;

    // transfer decode at the row strobe fall
    if (ras_fall && st_r.s2.cas_n && !st_r.s2.toe_n)
    begin
      st_nxt.xfer_set   = 1'b1;
      st_nxt.xfer_wr    = ~st_r.s2.upper_wr_n & ~st_r.s2.lower_wr_n;
      st_nxt.xfer_split = st_r.s2.split_sel;
    end
    if (stop_load)
    begin
      st_nxt.stop = st_r.s2.addr[vrsp_pkg::VRSP_STOP_W-1:0]; // R14 R16
    end
    if (cas_fall && st_r.xfer_set && !st_r.s2.ras_n)
    begin
      st_nxt.tap = st_r.s2.addr; // R10
    end

    // serial clock rise: data and pointer
    if (shift_rise)
    begin
      if (st_r.mode == vrsp_pkg::VRSP_MODE_READ && !st_r.s2.ser_en_n)
      begin
        st_nxt.ser_out = ser_word; // R3
      end
      if (jump_hit)
      begin
        st_nxt.ptr       = st_r.tap; // R17
        st_nxt.tap_empty = 1'b1;
      end
      else
      begin
        st_nxt.ptr = st_r.ptr + vrsp_pkg::VRSP_COL_ONE; // R22 R21 R13
      end
    end

    // single-transfer execution at the row strobe rise overrides a coincident advance
    if (exec_xfer)
    begin
      st_nxt.xfer_set = 1'b0;
      if (!st_r.xfer_split)
      begin
        st_nxt.mode      = st_r.xfer_wr ? vrsp_pkg::VRSP_MODE_WRITE
                                        : vrsp_pkg::VRSP_MODE_READ; // R2 R5 R18
        st_nxt.ptr       = st_r.tap; // R11 R18
        st_nxt.tap_empty = 1'b1; // R11
      end
      else
      begin
        // split keeps the mode; the start lands in the inactive half
        st_nxt.tap       = {~st_nxt.ptr[vrsp_pkg::VRSP_COL_W-1],
                            st_r.tap[vrsp_pkg::VRSP_COL_W-2:0]}; // R12 R20
        st_nxt.tap_empty = 1'b0;
      end
    end

    // output enable follows the enable pin only in read mode
    st_nxt.ser_oe = (st_nxt.mode == vrsp_pkg::VRSP_MODE_READ) & ~st_r.s2.ser_en_n; // R1 R4
    st_nxt.half   = st_nxt.ptr[vrsp_pkg::VRSP_COL_W-1]; // R9

    // apb: one wait state, answer registered
    st_nxt.pready  = apb_access & ~st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (apb_access && !st_r.pready)
    begin
      st_nxt.pslverr = ~is_mapped(paddr);
      st_nxt.prdata  = vrsp_pkg::VRSP_WORD_ZERO;
      if (!pwrite)
      begin
        unique case (paddr)
          vrsp_pkg::VRSP_STATUS_OFS:
          begin
            st_nxt.prdata[vrsp_pkg::VRSP_ST_MODE_BIT]  = (st_r.mode == vrsp_pkg::VRSP_MODE_READ);
            st_nxt.prdata[vrsp_pkg::VRSP_ST_EMPTY_BIT] = st_r.tap_empty;
            st_nxt.prdata[vrsp_pkg::VRSP_ST_HALF_BIT]  = st_r.half;
            st_nxt.prdata[vrsp_pkg::VRSP_ST_PEND_BIT]  = st_r.xfer_set;
            st_nxt.prdata[vrsp_pkg::VRSP_ST_PTR_LSB +: vrsp_pkg::VRSP_COL_W]   = st_r.ptr;
            st_nxt.prdata[vrsp_pkg::VRSP_ST_STOP_LSB +: vrsp_pkg::VRSP_STOP_W] = st_r.stop;
          end
          vrsp_pkg::VRSP_INDEX_OFS:
          begin
            st_nxt.prdata[vrsp_pkg::VRSP_COL_W-1:0] = st_r.index;
          end
          vrsp_pkg::VRSP_DATA_OFS:
          begin
            st_nxt.prdata[vrsp_pkg::VRSP_DATA_W-1:0] = apb_word;
          end
          default:
          begin
            st_nxt.prdata = vrsp_pkg::VRSP_WORD_ZERO;
          end
        endcase
      end
    end
    if (apb_access && st_r.pready && pwrite)
    begin
      if (paddr == vrsp_pkg::VRSP_INDEX_OFS)
      begin
        st_nxt.index = pwdata[vrsp_pkg::VRSP_COL_W-1:0];
      end
      else if (paddr == vrsp_pkg::VRSP_DATA_OFS)
      begin
        // index steps so software can stream a whole line
        st_nxt.index = st_r.index + vrsp_pkg::VRSP_COL_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r           <= '0;
      st_r.s1.ras_n  <= 1'b1;
      st_r.s2.ras_n  <= 1'b1;
      st_r.s1.cas_n  <= 1'b1;
      st_r.s2.cas_n  <= 1'b1;
      st_r.ras_d     <= 1'b1;
      st_r.cas_d     <= 1'b1;
      st_r.mode      <= vrsp_pkg::VRSP_MODE_WRITE; // R1
      st_r.tap_empty <= 1'b1;
      st_r.ptr       <= vrsp_pkg::VRSP_COL_ZERO;
      st_r.stop      <= vrsp_pkg::VRSP_STOP_RST; // R16
      st_r.ser_out   <= vrsp_pkg::VRSP_SER_ZERO;
      st_r.ser_oe    <= 1'b0; // R1
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // serial capture wins over a software write to the same column
  always_ff @(posedge pclk)
  begin
    if (apb_we)
    begin
      serial_reg[st_r.index] <= pwdata[vrsp_pkg::VRSP_DATA_W-1:0];
    end
    if (ser_we)
    begin
      serial_reg[st_r.ptr] <= st_r.s2.ser_data; // R7 R8
    end
  end

  assign pready               = st_r.pready;
  assign prdata               = st_r.prdata;
  assign pslverr              = st_r.pslverr;
  assign serial_data_pins_out = st_r.ser_out;
  assign serial_data_pins_oe  = st_r.ser_oe;
  assign half_select_flag     = st_r.half;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_oe_read_only;
    serial_data_pins_oe |-> st_r.mode == vrsp_pkg::VRSP_MODE_READ;
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("drive outside read mode"); // R1

  property p_read_word;
    shift_rise && st_r.mode == vrsp_pkg::VRSP_MODE_READ && !st_r.s2.ser_en_n && !exec_xfer
      |=> serial_data_pins_out == $past(ser_word) && serial_data_pins_oe;
  endproperty
  a_read_word: assert property (p_read_word) else $error("read word not driven"); // R3

  property p_float_high;
    shift_rise && st_r.s2.ser_en_n |=> !serial_data_pins_oe;
  endproperty
  a_float_high: assert property (p_float_high) else $error("pins driven with enable high"); // R4

  property p_advance;
    shift_rise && !jump_hit && !exec_xfer
      |=> st_r.ptr == $past(st_r.ptr) + vrsp_pkg::VRSP_COL_ONE;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance"); // R22

  property p_jump;
    shift_rise && jump_hit && !exec_xfer |=> st_r.ptr == $past(st_r.tap) && st_r.tap_empty;
  endproperty
  a_jump: assert property (p_jump) else $error("boundary jump missed"); // R17

  property p_wrap;
    shift_rise && st_r.tap_empty && st_r.ptr == vrsp_pkg::VRSP_COL_LAST && !exec_xfer
      |=> st_r.ptr == vrsp_pkg::VRSP_COL_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // R13

  property p_split_mode;
    exec_xfer && st_r.xfer_split |=> $stable(st_r.mode) && !st_r.tap_empty;
  endproperty
  a_split_mode: assert property (p_split_mode) else $error("split changed mode"); // R2

  property p_single_init;
    exec_xfer && !st_r.xfer_split
      |=> st_r.tap_empty && st_r.ptr == $past(st_r.tap) &&
          (st_r.mode == vrsp_pkg::VRSP_MODE_WRITE) == $past(st_r.xfer_wr);
  endproperty
  a_single_init: assert property (p_single_init) else $error("single transfer init wrong"); // R18

  property p_stop_load;
    stop_load |=> st_r.stop == $past(st_r.s2.addr[vrsp_pkg::VRSP_STOP_W-1:0]);
  endproperty
  a_stop_load: assert property (p_stop_load) else $error("jump register not loaded"); // R14

  // crossing a half boundary must flip the flag with the pointer
  property p_half_flag;
    shift_rise && !jump_hit && !exec_xfer && (&st_r.ptr[vrsp_pkg::VRSP_COL_W-2:0])
      |=> half_select_flag != $past(half_select_flag);
  endproperty
  a_half_flag: assert property (p_half_flag) else $error("half flag mismatch"); // R9

  property p_write_capture;
    ser_we |=> serial_reg[$past(st_r.ptr)] == $past(st_r.s2.ser_data);
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("serial word not captured"); // R7

  property p_write_skip;
    shift_rise && st_r.mode == vrsp_pkg::VRSP_MODE_WRITE && st_r.s2.ser_en_n && !apb_we
      |=> serial_reg[$past(st_r.ptr)] == $past(ser_word);
  endproperty
  a_write_skip: assert property (p_write_skip) else $error("masked column overwritten"); // R8

  property p_tap_load;
    cas_fall && st_r.xfer_set && !st_r.s2.ras_n |=> st_r.tap == $past(st_r.s2.addr);
  endproperty
  a_tap_load: assert property (p_tap_load) else $error("start point not loaded"); // R10

endmodule

// [test/vrsp_ctl_model.sv]
`timescale 1ns/100ps
module vrsp_ctl_model
(
  // clock
  input  wire logic        pclk,
  // strobes and address pins
  output logic             ras_n,
  output logic             cas_n,
  output logic             transfer_output_enable_n,
  output logic             upper_byte_write_n,
  output logic             lower_byte_write_n,
  output logic             split_sel,
  output logic [8:0]       addr,
  // serial side
  output logic             serial_shift_clock,
  output logic             serial_enable_n,
  output logic [15:0]      serial_data_drive
);
  initial
  begin
    ras_n = 1'h1;
    cas_n = 1'h1;
    transfer_output_enable_n = 1'h1;
    upper_byte_write_n = 1'h1;
    lower_byte_write_n = 1'h1;
    split_sel = 1'h0;
    addr = 9'h000;
    serial_shift_clock = 1'h0;
    serial_enable_n = 1'h1;
    serial_data_drive = 16'h0000;
  end

  task automatic hold4;
    repeat (4) @(posedge pclk);
  endtask

  // transfer cycle; no mask pins here, so a write transfer masks every bit
  task automatic xfer(input logic wr, input logic split, input logic [8:0] col);
    serial_data_drive <= ~serial_data_drive;
    ras_n <= 1'h0;
    transfer_output_enable_n <= 1'h0;
    upper_byte_write_n <= ~wr;
    lower_byte_write_n <= ~wr;
    split_sel <= split;
    hold4();
    cas_n <= 1'h0;
    addr <= col;
    hold4();
    ras_n <= 1'h1;
    hold4();
    cas_n <= 1'h1;
    transfer_output_enable_n <= 1'h1;
    upper_byte_write_n <= 1'h1;
    lower_byte_write_n <= 1'h1;
    split_sel <= 1'h0;
    addr <= ~col;
    hold4();
  endtask

  // refresh with column strobe first and both byte writes low
  task automatic stop_load(input logic [7:0] v);
    cas_n <= 1'h0;
    upper_byte_write_n <= 1'h0;
    lower_byte_write_n <= 1'h0;
    addr <= {1'h0, v};
    hold4();
    ras_n <= 1'h0;
    hold4();
    ras_n <= 1'h1;
    cas_n <= 1'h1;
    upper_byte_write_n <= 1'h1;
    lower_byte_write_n <= 1'h1;
    addr <= {1'h1, ~v};
    hold4();
  endtask

  // one 400 ns period; data set well before the rise, clock rests low
  task automatic sclk(input logic en_n, input logic [15:0] d);
    serial_enable_n <= en_n;
    serial_data_drive <= d;
    repeat (2) @(posedge pclk);
    serial_shift_clock <= 1'h1;
    hold4();
    serial_shift_clock <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// [test/video_ram_serial_port_pointer_tb.sv]
`timescale 1ns/100ps
module video_ram_serial_port_pointer_tb;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        ras_n, cas_n, transfer_output_enable_n, split_sel;
  logic        upper_byte_write_n, lower_byte_write_n;
  logic [8:0]  addr;
  logic        serial_shift_clock, serial_enable_n, serial_data_pins_oe, half_select_flag;
  logic [15:0] serial_data_pins_out, serial_data_drive, serial_data_pins_in;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;

  assign serial_data_pins_in = serial_data_pins_oe ? serial_data_pins_out : serial_data_drive;

  vrsp_serial_port dut_u
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .ras_n, .cas_n, .transfer_output_enable_n, .upper_byte_write_n,
    .lower_byte_write_n, .split_sel, .addr, .serial_shift_clock, .serial_enable_n,
    .serial_data_pins_in, .serial_data_pins_out, .serial_data_pins_oe, .half_select_flag
  );

  vrsp_ctl_model ctl_u
  (
    .pclk, .ras_n, .cas_n, .transfer_output_enable_n, .upper_byte_write_n,
    .lower_byte_write_n, .split_sel, .addr, .serial_shift_clock, .serial_enable_n,
    .serial_data_drive
  );

  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  // whole run needs about 420 cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles > 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [15:0] wv(input logic [8:0] c);
    return {7'h2B, c};
  endfunction

  task automatic st(input logic [7:0] s, input logic [8:0] p, input logic em, input logic m);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, {4'h0, s, 3'h0, p, 4'h0, 1'h0, p[8], em, m});
  endtask

  task automatic poke(input logic [8:0] c, input int n);
    apb(1'h1, 12'h004, {23'h0, c});
    for (int i = 0; i < n; i++)
      apb(1'h1, 12'h008, {16'h0, wv(9'(c + i))});
  endtask

  task automatic peek(input logic [8:0] c, input logic [15:0] x);
    apb(1'h1, 12'h004, {23'h0, c});
    apb(1'h0, 12'h008, 32'h0);
    chk(q, {16'h0, x});
  endtask

  task automatic rd_out(input logic [8:0] c);
    chk({15'h0, serial_data_pins_oe, serial_data_pins_out}, {15'h0, 1'h1, wv(c)});
  endtask

  task automatic t_reset;
    st(8'hFF, 9'h000, 1'h1, 1'h0);
    chk({30'h0, serial_data_pins_oe, half_select_flag}, 32'h0);
    apb(1'h0, 12'h00C, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000);
    apb(1'h1, 12'h004, 32'hFFFF_FE05);
    apb(1'h0, 12'h004, 32'h0);
    chk(q, 32'h0000_0005);
    poke(9'h0FE, 6);
    poke(9'h1FE, 3);
    poke(9'h07D, 3);
    poke(9'h110, 2);
    poke(9'h020, 3);
    $display("test reset done");
  endtask

  task automatic t_read;
    ctl_u.xfer(1'h0, 1'h0, 9'h0FE);
    st(8'hFF, 9'h0FE, 1'h1, 1'h1);
    for (int k = 0; k < 3; k++)
    begin
      ctl_u.sclk(1'h0, 16'h0000);
      rd_out(9'(9'h0FE + k));
      chk({31'h0, half_select_flag}, {31'h0, k > 0});
    end
    $display("test read done");
  endtask

  task automatic t_skip;
    ctl_u.sclk(1'h1, 16'h0000);
    ctl_u.sclk(1'h1, 16'h0000);
    chk({31'h0, serial_data_pins_oe}, 32'h0);
    st(8'hFF, 9'h103, 1'h1, 1'h1);
    ctl_u.sclk(1'h0, 16'h0000);
    rd_out(9'h103);
    ctl_u.xfer(1'h1, 1'h1, 9'h000);
    st(8'hFF, 9'h104, 1'h0, 1'h1);
    $display("test skip done");
  endtask

  task automatic t_write;
    ctl_u.xfer(1'h1, 1'h0, 9'h020);
    st(8'hFF, 9'h020, 1'h1, 1'h0);
    ctl_u.sclk(1'h0, 16'hBEEF);
    ctl_u.sclk(1'h1, 16'h1111);
    ctl_u.sclk(1'h0, 16'hCAFE);
    chk({31'h0, serial_data_pins_oe}, 32'h0);
    peek(9'h020, 16'hBEEF);
    peek(9'h021, wv(9'h021));
    peek(9'h022, 16'hCAFE);
    ctl_u.xfer(1'h0, 1'h1, 9'h000);
    st(8'hFF, 9'h023, 1'h0, 1'h0);
    $display("test write done");
  endtask

  // empty start point: column 511 is a jump source but must not be taken
  task automatic t_wrap;
    ctl_u.xfer(1'h0, 1'h0, 9'h1FE);
    for (int k = 0; k < 3; k++)
    begin
      ctl_u.sclk(1'h0, 16'h0000);
      rd_out(9'(9'h1FE + k));
    end
    st(8'hFF, 9'h001, 1'h1, 1'h1);
    $display("test wrap done");
  endtask

  task automatic t_jump;
    ctl_u.stop_load(8'h7F);
    st(8'h7F, 9'h001, 1'h1, 1'h1);
    ctl_u.xfer(1'h0, 1'h0, 9'h07D);
    ctl_u.sclk(1'h0, 16'h0000);
    rd_out(9'h07D);
    ctl_u.xfer(1'h0, 1'h1, 9'h010);
    st(8'h7F, 9'h07E, 1'h0, 1'h1);
    ctl_u.sclk(1'h0, 16'h0000);
    rd_out(9'h07E);
    ctl_u.sclk(1'h0, 16'h0000);
    rd_out(9'h07F);
    st(8'h7F, 9'h110, 1'h1, 1'h1);
    chk({31'h0, half_select_flag}, 32'h1);
    ctl_u.sclk(1'h0, 16'h0000);
    rd_out(9'h110);
    $display("test jump done");
  endtask

  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_read();
    t_skip();
    t_write();
    t_wrap();
    t_jump();
    end_of_test();
  end
endmodule
